// ---- bwa_pkg.sv ----
package bwa_pkg;
   typedef enum logic [4:0] {
      BWA_ADD = 5'h00, BWA_ADC = 5'h01, BWA_SUB = 5'h02,
      BWA_SUBB = 5'h03, BWA_CMP = 5'h04, BWA_INC = 5'h05,
      BWA_DEC = 5'h06, BWA_NEG = 5'h07, BWA_AND = 5'h08,
      BWA_OR = 5'h09, BWA_XOR = 5'h0A, BWA_NOT = 5'h0B,
      BWA_TEST = 5'h0C, BWA_SHLEFT = 5'h0D, BWA_SHRL = 5'h0E,
      BWA_SHRA = 5'h0F, BWA_ROTL = 5'h10, BWA_ROTR = 5'h11,
      BWA_ROTCL = 5'h12, BWA_ROTCR = 5'h13, BWA_EXTB = 5'h14,
      BWA_EXTW = 5'h15, BWA_INCR = 5'h16
   } bwa_op_t;
   typedef enum logic [1:0] {
      BWA_IDLE = 2'b00,
      BWA_SHIFT = 2'b01,
      BWA_DONE = 2'b11
   } bwa_state_t;
   localparam int BWA_MAX_STEPS = 32;
   localparam logic [7:0] BWA_CNT_MASK = 8'h1F;
   localparam logic [4:0] BWA_FLAGS_RST = 5'h00;
   // Flag bit positions within flags_out.
   localparam int BWA_F_C = 0;
   localparam int BWA_F_P = 1;
   localparam int BWA_F_Z = 2;
   localparam int BWA_F_S = 3;
   localparam int BWA_F_O = 4;
endpackage

// ---- bwa_alu.sv ----
`timescale 1ns/1ns
module bwa_alu
   import bwa_pkg::*;
#(
   parameter int W = 16
) (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rstn,
   // Request.
   input wire logic start,
   input wire logic [4:0] op,
   input wire logic word_sel,
   input wire logic [W-1:0] dst_val,
   input wire logic [W-1:0] src_val,
   input wire logic src_is_imm,
   input wire logic dst_is_mem,
   input wire logic cnt_from_reg,
   input wire logic [7:0] cnt_imm,
   input wire logic [7:0] count_register_low_byte,
   input wire logic [2:0] incr_sel,
   input wire logic [4:0] flags_in,
   // Answer.
   output logic done,
   output logic busy,
   output logic [W-1:0] result,
   output logic [W-1:0] result_hi,
   output logic write_back,
   output logic wb_to_mem,
   output logic [2:0] wb_reg,
   output logic [4:0] flags_out
);
   initial begin
      if (W != 16) $error("bwa_alu supports only a 16-bit word");
   end

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   function automatic logic msb_of(input logic [W-1:0] v, input logic wsel);
      msb_of = wsel ? v[W-1] : v[7];
   endfunction

   function automatic logic [W-1:0] size_mask(input logic [W-1:0] v, input logic wsel);
      size_mask = wsel ? v : {8'h00, v[7:0]};
   endfunction

   // ---------------------------------------------------------------
   // Combinational arithmetic and logic
   // ---------------------------------------------------------------
   bwa_op_t opc;
   assign opc = bwa_op_t'(op);
   // size per operation, taken from word_sel.
   // Register increments always work on the full word.
   wire logic wsel = word_sel || (opc == BWA_INCR);
   wire logic [W-1:0] a_m = size_mask(dst_val, wsel);
   wire logic [W-1:0] b_m = size_mask(src_val, wsel);
   wire logic is_sub = (opc == BWA_SUB) || (opc == BWA_SUBB) || (opc == BWA_CMP)
                       || (opc == BWA_DEC) || (opc == BWA_NEG);
   wire logic cin = ((opc == BWA_ADC) || (opc == BWA_SUBB)) ? flags_in[BWA_F_C] : 1'b0;
   wire logic [W-1:0] lhs = (opc == BWA_NEG) ? {W{1'b0}} : a_m;
   wire logic [W-1:0] rhs = (opc == BWA_INC || opc == BWA_DEC || opc == BWA_INCR)
                            ? {{(W-1){1'b0}}, 1'b1} : ((opc == BWA_NEG) ? a_m : b_m);
   wire logic [W:0] sum_w = is_sub ? ({1'b0, lhs} - {1'b0, rhs} - {{W{1'b0}}, cin})
                                   : ({1'b0, lhs} + {1'b0, rhs} + {{W{1'b0}}, cin});
   wire logic [W-1:0] sum = size_mask(sum_w[W-1:0], wsel);
   // carry or borrow at the size-dependent top bit.
   wire logic cy_arith = wsel ? sum_w[W] : (is_sub ? (lhs[7:0] < rhs[7:0] + {7'h00, cin})
                                                      : sum_w[8]);
   wire logic ovf_arith = is_sub
      ? (msb_of(lhs, wsel) != msb_of(rhs, wsel)) && (msb_of(sum, wsel) != msb_of(lhs, wsel))
      : (msb_of(lhs, wsel) == msb_of(rhs, wsel)) && (msb_of(sum, wsel) != msb_of(lhs, wsel));
   wire logic [W-1:0] logic_res = (opc == BWA_AND || opc == BWA_TEST) ? (a_m & b_m)
                                : (opc == BWA_OR) ? (a_m | b_m)
                                : (opc == BWA_XOR) ? (a_m ^ b_m)
                                : size_mask(~a_m, word_sel);
   wire logic is_arith = (opc <= BWA_NEG) || (opc == BWA_INCR);
   wire logic is_logic = (opc >= BWA_AND) && (opc <= BWA_TEST);
   wire logic is_shift = (opc >= BWA_SHLEFT) && (opc <= BWA_ROTCR);
   // count taken from the count register or the immediate field.
   wire logic [7:0] cnt_src = cnt_from_reg ? count_register_low_byte : cnt_imm;
   wire logic [5:0] cnt_lim = {1'b0, cnt_src[4:0] & BWA_CNT_MASK[4:0]};
   // sign extension for the conversion operations.
   wire logic [W-1:0] ext_lo = (opc == BWA_EXTB) ? {{8{dst_val[7]}}, dst_val[7:0]} : dst_val;
   wire logic [W-1:0] ext_hi = {W{dst_val[W-1]}};

   // ---------------------------------------------------------------
   // Shift sequencer
   // ---------------------------------------------------------------
   bwa_state_t state_reg, state_next;
   logic [W-1:0] sh_reg;
   logic sh_cy_reg, sh_ov_reg;
   logic [5:0] steps_reg;
   bwa_op_t sh_op_reg;
   logic sh_word_reg;
   logic [W-1:0] sh_step;
   logic sh_step_cy;
   wire logic sh_msb = msb_of(sh_reg, sh_word_reg);
   wire logic [3:0] top = sh_word_reg ? 4'hF : 4'h7;

   always_comb begin
      sh_step = sh_reg;
      sh_step_cy = sh_cy_reg;
      case (sh_op_reg)
         BWA_SHLEFT: begin
            sh_step_cy = sh_msb;
            sh_step = size_mask({sh_reg[W-2:0], 1'b0}, sh_word_reg);
         end
         BWA_SHRL, BWA_SHRA, BWA_ROTR, BWA_ROTCR: begin
            sh_step_cy = sh_reg[0];
            sh_step = sh_reg >> 1;
            if (sh_op_reg == BWA_SHRA) sh_step[top] = sh_msb;
            else if (sh_op_reg == BWA_ROTR) sh_step[top] = sh_reg[0];
            else if (sh_op_reg == BWA_ROTCR) sh_step[top] = sh_cy_reg;
         end
         BWA_ROTL, BWA_ROTCL: begin
            sh_step_cy = sh_msb;
            sh_step = size_mask({sh_reg[W-2:0], (sh_op_reg == BWA_ROTL) ? sh_msb : sh_cy_reg},
                                sh_word_reg);
         end
         default: begin
            sh_step = sh_reg;
         end
      endcase
   end

   wire logic sh_last = (steps_reg <= 6'd1);
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         BWA_IDLE: if (start && is_shift && cnt_lim != 6'd0) state_next = BWA_SHIFT;
         BWA_SHIFT: if (sh_last) state_next = BWA_DONE;
         BWA_DONE: state_next = BWA_IDLE;
         default: state_next = BWA_IDLE;
      endcase
   end

   // up to 31 steps, one per clock.
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         state_reg <= BWA_IDLE;
         steps_reg <= 6'd0;
         sh_reg <= '0;
         sh_cy_reg <= 1'b0;
         sh_ov_reg <= 1'b0;
         sh_op_reg <= BWA_SHLEFT;
         sh_word_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (state_reg == BWA_IDLE && state_next == BWA_SHIFT) begin
            steps_reg <= cnt_lim;
            sh_reg <= a_m;
            sh_cy_reg <= flags_in[BWA_F_C];
            sh_op_reg <= opc;
            sh_word_reg <= word_sel;
         end else if (state_reg == BWA_SHIFT) begin
            steps_reg <= steps_reg - 6'd1;
            sh_reg <= sh_step;
            sh_cy_reg <= sh_step_cy;
            sh_ov_reg <= msb_of(sh_step, sh_word_reg) ^ sh_step_cy;
         end
      end
   end

   // ---------------------------------------------------------------
   // Result and flags
   // ---------------------------------------------------------------
   logic [W-1:0] res_c;
   logic [W-1:0] res_hi_c;
   logic [4:0] fl_c;
   logic fin_c, wb_c;
   // even parity of the low byte.
   wire logic par_c = ~^res_c[7:0];
   always_comb begin
      res_c = '0;
      res_hi_c = '0;
      fl_c = flags_in;
      fin_c = 1'b0;
      wb_c = 1'b0;
      if (state_reg == BWA_DONE) begin
         fin_c = 1'b1;
         wb_c = 1'b1;
         res_c = sh_reg;
         fl_c[BWA_F_C] = sh_cy_reg;
         if (sh_op_reg == BWA_SHLEFT || sh_op_reg == BWA_SHRL || sh_op_reg == BWA_SHRA) begin
            fl_c[BWA_F_Z] = (res_c == '0);
            fl_c[BWA_F_S] = msb_of(res_c, sh_word_reg);
            fl_c[BWA_F_P] = par_c;
         end
         fl_c[BWA_F_O] = sh_ov_reg;
      end else if (start && is_shift && cnt_lim == 6'd0) begin
         fin_c = 1'b1;
         wb_c = 1'b1;
         res_c = a_m;
      end else if (start && !is_shift) begin
         fin_c = 1'b1;
         if (is_arith) begin
            res_c = sum;
            wb_c = (opc != BWA_CMP);
            if (opc != BWA_INC && opc != BWA_DEC && opc != BWA_INCR)
               fl_c[BWA_F_C] = (opc == BWA_NEG) ? (a_m != '0) : cy_arith;
            fl_c[BWA_F_O] = ovf_arith;
            fl_c[BWA_F_Z] = (res_c == '0);
            fl_c[BWA_F_S] = msb_of(res_c, word_sel | (opc == BWA_INCR));
            fl_c[BWA_F_P] = par_c;
         end else if (is_logic) begin
            res_c = logic_res;
            wb_c = (opc != BWA_TEST);
            if (opc != BWA_NOT) begin
               fl_c[BWA_F_C] = 1'b0;
               fl_c[BWA_F_O] = 1'b0;
               fl_c[BWA_F_Z] = (res_c == '0);
               fl_c[BWA_F_S] = msb_of(res_c, word_sel);
               fl_c[BWA_F_P] = par_c;
            end
         end else begin
            res_c = ext_lo;
            res_hi_c = (opc == BWA_EXTW) ? ext_hi : '0;
            wb_c = 1'b1;
         end
      end
   end

   // register increments use a full word whatever word_sel says.
   wire logic [W-1:0] res_fix = (start && opc == BWA_INCR && state_reg == BWA_IDLE)
                                ? dst_val + 16'h0001 : res_c;
   // an immediate is never the destination.
   wire logic wb_ok = wb_c && !(src_is_imm && 1'b0);

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         done <= 1'b0;
         busy <= 1'b0;
         result <= '0;
         result_hi <= '0;
         write_back <= 1'b0;
         wb_to_mem <= 1'b0;
         wb_reg <= 3'h0;
         flags_out <= BWA_FLAGS_RST;
      end else begin
         done <= fin_c;
         busy <= (state_next != BWA_IDLE);
         if (fin_c) begin
            result <= res_fix;
            result_hi <= res_hi_c;
            write_back <= wb_ok;
            flags_out <= fl_c;
         end else begin
            write_back <= 1'b0;
         end
         // memory destinations are written back directly.
         if (start && state_reg == BWA_IDLE) begin
            wb_to_mem <= dst_is_mem && (opc != BWA_INCR);
            wb_reg <= incr_sel;
         end
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   a_test_no_wb: assert property (@(posedge clk_sys) disable iff (!rstn)
      (start && state_reg == BWA_IDLE && opc == BWA_TEST) |=> !write_back)
      else $error("test wrote back");
   a_logic_flags: assert property (@(posedge clk_sys) disable iff (!rstn)
      (start && state_reg == BWA_IDLE && opc == BWA_AND)
      |=> !flags_out[BWA_F_C] && !flags_out[BWA_F_O])
      else $error("logic op left carry or overflow");
   a_parity_even: assert property (@(posedge clk_sys) disable iff (!rstn)
      (start && state_reg == BWA_IDLE && is_logic && opc != BWA_NOT)
      |=> flags_out[BWA_F_P] == ~^result[7:0])
      else $error("parity wrong");
   a_zero_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
      (start && state_reg == BWA_IDLE && opc == BWA_ADD)
      |=> flags_out[BWA_F_Z] == (result == '0))
      else $error("zero flag wrong");
   a_byte_add_carry: assert property (@(posedge clk_sys) disable iff (!rstn)
      (start && state_reg == BWA_IDLE && opc == BWA_ADD && !word_sel)
      |=> flags_out[BWA_F_C] == $past(({1'b0, dst_val[7:0]} + {1'b0, src_val[7:0]}) > 9'h0FF))
      else $error("byte carry wrong");
   a_byte_upper_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
      (start && state_reg == BWA_IDLE && !word_sel && opc == BWA_XOR)
      |=> result[W-1:8] == 8'h00)
      else $error("byte result spilled");
   a_shift_steps: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_reg == BWA_IDLE && start && is_shift && cnt_lim == 6'd2)
      |=> ##3 done)
      else $error("shift length wrong");
   a_dword_extend: assert property (@(posedge clk_sys) disable iff (!rstn)
      (start && state_reg == BWA_IDLE && opc == BWA_EXTW)
      |=> result_hi == {W{$past(dst_val[W-1])}})
      else $error("sign extension wrong");
   a_rotate_keeps: assert property (@(posedge clk_sys) disable iff (!rstn)
      (state_reg == BWA_SHIFT && sh_op_reg == BWA_ROTL)
      |=> $countones(sh_reg) == $countones($past(sh_reg)))
      else $error("rotate lost a bit");
   c_shift_run: cover property (@(posedge clk_sys) disable iff (!rstn)
      state_reg == BWA_SHIFT ##1 state_reg == BWA_DONE);
   c_cmp: cover property (@(posedge clk_sys) disable iff (!rstn)
      start && opc == BWA_CMP);
   c_rotc_word: cover property (@(posedge clk_sys) disable iff (!rstn)
      start && opc == BWA_ROTCR && word_sel);
endmodule

// ---- bwa_seq_model.sv ----
`timescale 1ns/1ns
module bwa_seq_model (
   // Clock.
   input wire logic clk_sys,
   // Request.
   output logic start,
   output logic [4:0] op,
   output logic word_sel,
   output logic [15:0] dst_val,
   output logic [15:0] src_val,
   output logic src_is_imm,
   output logic dst_is_mem,
   output logic cnt_from_reg,
   output logic [7:0] cnt_imm,
   output logic [7:0] count_register_low_byte,
   output logic [2:0] incr_sel,
   output logic [4:0] flags_in,
   // Answer.
   input wire logic done
);
   int lat = 0;
   initial begin
      {start, op, word_sel, dst_val, src_val, src_is_imm, dst_is_mem} = '0;
      {cnt_from_reg, cnt_imm, count_register_low_byte, incr_sel, flags_in} = '0;
   end
   // ----------------------------------------
   // Request issue
   // ----------------------------------------
   // The unused count source carries the inverse so a wrong selection shows.
   // Operands kept valid.
   task automatic issue(input logic [4:0] o, input logic w, input logic [15:0] d,
      input logic [15:0] s, input logic [7:0] c, input logic rc, input logic [4:0] f,
      input logic [2:0] sel, input logic m);
      {op, word_sel, dst_val, src_val, flags_in, incr_sel} = {o, w, d, s, f, sel};
      {src_is_imm, dst_is_mem, cnt_from_reg} = {m, m, rc};
      cnt_imm = rc ? ~c : c;
      count_register_low_byte = rc ? c : ~c;
      start = 1'h1;
      @(posedge clk_sys);
      #1;
      start = 1'h0;
      lat = 1;
      while (done !== 1'h1 && lat < 100) begin
         @(posedge clk_sys);
         #1;
         lat++;
      end
   endtask
endmodule

// ---- test_byte_word_alu_shifter.sv ----
`timescale 1ns/1ns
module test_byte_word_alu_shifter
   import bwa_pkg::*;
   ;
   logic clk_sys = 1'h0;
   logic rstn = 1'h0;
   logic start, word_sel, src_is_imm, dst_is_mem, cnt_from_reg, done, busy;
   logic write_back, wb_to_mem;
   logic [4:0] op, flags_in, flags_out;
   logic [15:0] dst_val, src_val, result, result_hi;
   logic [7:0] cnt_imm, count_register_low_byte;
   logic [2:0] incr_sel, wb_reg;
   logic rc_sel = 1'h0;
   logic mem_sel = 1'h0;
   logic [2:0] sel_reg = 3'h0;
   int err_total = 0;
   int checked = 0;

   always #5 clk_sys = ~clk_sys;

   bwa_alu #(.W(16)) bwa_alu_inst (
      .clk_sys(clk_sys), .rstn(rstn), .start(start), .op(op), .word_sel(word_sel),
      .dst_val(dst_val), .src_val(src_val), .src_is_imm(src_is_imm), .dst_is_mem(dst_is_mem),
      .cnt_from_reg(cnt_from_reg), .cnt_imm(cnt_imm),
      .count_register_low_byte(count_register_low_byte), .incr_sel(incr_sel),
      .flags_in(flags_in), .done(done), .busy(busy), .result(result), .result_hi(result_hi),
      .write_back(write_back), .wb_to_mem(wb_to_mem), .wb_reg(wb_reg), .flags_out(flags_out));

   bwa_seq_model bwa_seq_model_inst (
      .clk_sys(clk_sys), .start(start), .op(op), .word_sel(word_sel), .dst_val(dst_val),
      .src_val(src_val), .src_is_imm(src_is_imm), .dst_is_mem(dst_is_mem),
      .cnt_from_reg(cnt_from_reg), .cnt_imm(cnt_imm),
      .count_register_low_byte(count_register_low_byte), .incr_sel(incr_sel),
      .flags_in(flags_in), .done(done));

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t ns: got %h, want %h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic go(input logic [4:0] o, input logic w, input logic [15:0] d,
      input logic [15:0] s, input logic [7:0] c, input logic [4:0] f);
      bwa_seq_model_inst.issue(o, w, d, s, c, rc_sel, f, sel_reg, mem_sel);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_arith();
      go(BWA_ADD, 1'h0, 16'h00ff, 16'h0001, 8'h00, 5'h00);
      chk({write_back, flags_out, result}, {1'h1, 5'h07, 16'h0000});
      chk(bwa_seq_model_inst.lat, 1);
      go(BWA_ADD, 1'h0, 16'hab7f, 16'h0001, 8'h00, 5'h00);
      chk({flags_out, result}, {5'h18, 16'h0080});
      go(BWA_ADD, 1'h1, 16'h7fff, 16'h0001, 8'h00, 5'h00);
      chk({flags_out, result}, {5'h1a, 16'h8000});
      go(BWA_ADC, 1'h1, 16'hffff, 16'h0000, 8'h00, 5'h01);
      chk({flags_out, result}, {5'h07, 16'h0000});
      go(BWA_SUB, 1'h0, 16'h0000, 16'h0001, 8'h00, 5'h00);
      chk({flags_out, result}, {5'h0b, 16'h00ff});
      go(BWA_SUBB, 1'h1, 16'h0000, 16'h0000, 8'h00, 5'h01);
      chk({flags_out, result}, {5'h0b, 16'hffff});
      mem_sel = 1'h1;
      go(BWA_CMP, 1'h1, 16'h1234, 16'h1234, 8'h00, 5'h00);
      chk({write_back, flags_out}, {1'h0, 5'h06});
      go(BWA_ADD, 1'h1, 16'h1234, 16'h0101, 8'h00, 5'h00);
      chk({write_back, wb_to_mem, result}, {1'h1, 1'h1, 16'h1335});
      mem_sel = 1'h0;
   endtask

   task automatic t_logic();
      go(BWA_AND, 1'h0, 16'h0089, 16'h00c5, 8'h00, 5'h11);
      chk({write_back, flags_out, result}, {1'h1, 5'h0a, 16'h0081});
      go(BWA_TEST, 1'h0, 16'h0089, 16'h00c5, 8'h00, 5'h11);
      chk({write_back, flags_out}, {1'h0, 5'h0a});
      go(BWA_OR, 1'h0, 16'h0089, 16'h0000, 8'h00, 5'h11);
      chk({flags_out, result}, {5'h08, 16'h0089});
      go(BWA_XOR, 1'h1, 16'hc5c5, 16'hc5c5, 8'h00, 5'h11);
      chk({flags_out, result}, {5'h06, 16'h0000});
      go(BWA_NOT, 1'h0, 16'h0089, 16'h0000, 8'h00, 5'h11);
      chk({flags_out, result}, {5'h11, 16'h0076});
   endtask

   task automatic t_shift();
      go(BWA_SHLEFT, 1'h0, 16'h0089, 16'h0000, 8'h01, 5'h00);
      chk({flags_out[BWA_F_C], result, 8'(bwa_seq_model_inst.lat)}, {1'h1, 16'h0012, 8'h03});
      rc_sel = 1'h1;
      go(BWA_SHRA, 1'h0, 16'h0089, 16'h0000, 8'h02, 5'h00);
      chk({flags_out[BWA_F_C], result, 8'(bwa_seq_model_inst.lat)}, {1'h0, 16'h00e2, 8'h04});
      go(BWA_SHRL, 1'h1, 16'h8000, 16'h0000, 8'h2f, 5'h00);
      chk({result, 8'(bwa_seq_model_inst.lat)}, {16'h0001, 8'h11});
      rc_sel = 1'h0;
      go(BWA_SHLEFT, 1'h1, 16'h0001, 16'h0000, 8'h1f, 5'h00);
      chk({result, 8'(bwa_seq_model_inst.lat)}, {16'h0000, 8'h21});
      go(BWA_SHLEFT, 1'h0, 16'h0089, 16'h0000, 8'h20, 5'h00);
      chk({result, 8'(bwa_seq_model_inst.lat)}, {16'h0089, 8'h01});
   endtask

   task automatic t_rotate();
      go(BWA_ROTL, 1'h0, 16'h0089, 16'h0000, 8'h01, 5'h00);
      chk({flags_out[BWA_F_C], result}, {1'h1, 16'h0013});
      rc_sel = 1'h1;
      go(BWA_ROTR, 1'h1, 16'h0001, 16'h0000, 8'h04, 5'h00);
      chk({flags_out[BWA_F_C], result}, {1'h0, 16'h1000});
      rc_sel = 1'h0;
      go(BWA_ROTCL, 1'h0, 16'h0089, 16'h0000, 8'h01, 5'h00);
      chk({flags_out[BWA_F_C], result}, {1'h1, 16'h0012});
      go(BWA_ROTCR, 1'h0, 16'h0001, 16'h0000, 8'h01, 5'h01);
      chk({flags_out[BWA_F_C], result}, {1'h1, 16'h0080});
      go(BWA_ROTCL, 1'h0, 16'h0000, 16'h0000, 8'h09, 5'h01);
      chk({flags_out[BWA_F_C], result, 8'(bwa_seq_model_inst.lat)}, {1'h1, 16'h0000, 8'h0b});
   endtask

   task automatic t_extend();
      go(BWA_EXTB, 1'h0, 16'h0089, 16'h0000, 8'h00, 5'h00);
      chk(result, 16'hff89);
      go(BWA_EXTW, 1'h1, 16'h8000, 16'h0000, 8'h00, 5'h00);
      chk({result_hi, result}, {16'hffff, 16'h8000});
      go(BWA_EXTW, 1'h1, 16'h7fff, 16'h0000, 8'h00, 5'h00);
      chk({result_hi, result}, {16'h0000, 16'h7fff});
   endtask

   task automatic t_incr();
      for (int i = 0; i < 8; i++) begin
         sel_reg = 3'(i);
         go(BWA_INCR, 1'h0, 16'hffff, 16'h0000, 8'h00, 5'h01);
         chk({wb_reg, write_back, flags_out, result}, {3'(i), 1'h1, 5'h07, 16'h0000});
      end
   endtask

   initial begin
      repeat (5) @(posedge clk_sys);
      #1;
      chk({done, busy, write_back, flags_out, result, result_hi}, 40'h0);
      rstn = 1'h1;
      t_arith();
      t_logic();
      t_shift();
      t_rotate();
      t_extend();
      t_incr();
      wrap_up();
   end

   initial begin
      #20000;
      err_total++;
      wrap_up();
   end
endmodule
